// ### common/remote_io_defs.vh
// Register addresses, reset values, variant counts and timing constants of the remote I/O bank
`ifndef REMOTE_IO_DEFS_VH
`define REMOTE_IO_DEFS_VH
// Coil addresses
`define COIL_OUT_STATE 16'h0000
`define COIL_CLR_HIGH 16'h0020
`define COIL_CLR_LOW 16'h0021
`define COIL_CLR_CNT 16'h0022
`define COIL_SAVE 16'h003C
`define COIL_PWM_EN 16'h0064
`define COIL_LATCH_EN 16'h0096
`define COIL_CNT_EN 16'h0097
`define COIL_FREQ_EN 16'h00BE
`define COIL_PWRON 16'h00EB
`define COIL_SAFE 16'h010B
// Discrete input addresses
`define DI_HIGH_LATCH 16'h0020
// Holding register addresses
`define HR_RESET_CAUSE 16'h00FF
`define HR_WDT_TIMEOUT 16'h0101
`define HR_WDT_EVENTS 16'h0102
`define HR_MODULE_NAME 16'h0103
`define HR_CONN_TIMEOUT 16'h0107
`define HR_SYS_TIMEOUT 16'h0108
// Reset values and codes
`define WDT_TIMEOUT_RST 16'h0000
`define CONN_TIMEOUT_RST 16'h0000
`define SYS_TIMEOUT_RST 16'h0000
`define CAUSE_POWER_ON 16'h0001
`define CAUSE_WATCHDOG 16'h0002
`define CAUSE_COMMAND 16'h0003
// Enable thresholds in seconds
`define WDT_MIN_S 16'h0005
`define CONN_MIN_S 16'h0005
`define SYS_MIN_S 16'h001E
// Channel counts of the variant (two of each)
`define OUT_CHANNELS 8'h02
`define IN_CHANNELS 8'h02
// Timing
`define CLK_HZ 25000000
`define SECOND_CYCLES (`CLK_HZ)
`endif

// ### rtl/remote_io_control_registers.v
// Register bank of the remote digital I/O module: coils, discrete inputs and holding registers
`timescale 1ns/1ps
`default_nettype none
`include "remote_io_defs.vh"

module remote_io_control_registers #(
    parameter SECOND_CYCLES = `SECOND_CYCLES,
    parameter [15:0] MODULE_NAME = 16'h5A5A // Arbitrary identification value
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire en_i,
    // Register access from the protocol engine, same clock
    input wire coil_wr_i,
    input wire coil_rd_i,
    input wire di_rd_i,
    input wire hr_wr_i,
    input wire hr_rd_i,
    input wire [15:0] addr_i,
    input wire [15:0] wdata_i,
    output reg [15:0] rdata_o,
    output reg rvalid_o,
    output reg rerr_o,
    // Events
    input wire host_activity_i,
    input wire cmd_reset_i,
    input wire wdt_reset_i,
    input wire [`IN_CHANNELS-1:0] din_i,
    input wire flash_busy_i,
    // Block outputs
    output reg [`OUT_CHANNELS-1:0] dout_o,
    output reg [`OUT_CHANNELS-1:0] pwm_en_o,
    output reg [`IN_CHANNELS-1:0] cnt_en_o,
    output reg [`IN_CHANNELS-1:0] freq_en_o,
    output reg latch_en_o,
    output reg [`IN_CHANNELS-1:0] cnt_clr_o,
    output reg save_o,
    output reg [`IN_CHANNELS-1:0] high_latch_o,
    output reg [`IN_CHANNELS-1:0] low_latch_o,
    output reg safe_state_o,
    output reg conn_timeout_en_o,
    output reg sys_timeout_en_o,
    output reg [15:0] conn_timeout_o,
    output reg [15:0] sys_timeout_o,
    output reg [7:0] in_count_o,
    output reg [7:0] out_count_o
);

function in_range;
    input [15:0] a;
    input [15:0] base;
    input [7:0] n;
    begin
        in_range = (a >= base) && (a < base + {8'h00, n});
    end
endfunction

// Coil and flag bits read back in bit 0 of the word
function [15:0] bit_word;
    input b;
    begin
        bit_word = {15'h0000, b};
    end
endfunction

// A timeout only runs from its threshold upward; smaller values mean off
function at_least;
    input [15:0] v;
    input [15:0] lim;
    begin
        at_least = (v >= lim);
    end
endfunction

// Pulse coils act only on a written 1; a written 0 is accepted and does nothing
function pulse_hit;
    input wr;
    input [15:0] a;
    input [15:0] target;
    input b;
    begin
        pulse_hit = wr && (a == target) && b;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// State

reg [`OUT_CHANNELS-1:0] out_state_r;
reg [`OUT_CHANNELS-1:0] pwm_en_r;
reg [`OUT_CHANNELS-1:0] pwron_r;
reg [`OUT_CHANNELS-1:0] safe_r;
reg [`IN_CHANNELS-1:0] cnt_en_r;
reg [`IN_CHANNELS-1:0] freq_en_r;
reg latch_en_r;
reg [`IN_CHANNELS-1:0] hi_latch_r;
reg [`IN_CHANNELS-1:0] lo_latch_r;
reg [15:0] cause_r;
reg [15:0] wdt_to_r;
reg [15:0] wdt_events_r;
reg [15:0] conn_to_r;
reg [15:0] sys_to_r;
reg [31:0] tick_r;
reg [15:0] wdt_sec_r;
reg wdt_fault_r;
reg pwron_done_r;
reg [`IN_CHANNELS-1:0] din_s1_r;
reg [`IN_CHANNELS-1:0] din_s2_r;
reg [`IN_CHANNELS-1:0] din_prev_r;

// Pin inputs through two flip-flops
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        din_s1_r <= {`IN_CHANNELS{1'b0}};
        din_s2_r <= {`IN_CHANNELS{1'b0}};
        din_prev_r <= {`IN_CHANNELS{1'b0}};
    end else if (en_i) begin
        din_s1_r <= din_i;
        din_s2_r <= din_s1_r;
        din_prev_r <= din_s2_r;
    end
end

wire coil_we = coil_wr_i;
wire hit_out = in_range(addr_i, `COIL_OUT_STATE, `OUT_CHANNELS);
wire hit_pwm = in_range(addr_i, `COIL_PWM_EN, `OUT_CHANNELS);
wire hit_pwron = in_range(addr_i, `COIL_PWRON, `OUT_CHANNELS);
wire hit_safe = in_range(addr_i, `COIL_SAFE, `OUT_CHANNELS);
wire hit_cnt = in_range(addr_i, `COIL_CNT_EN, `IN_CHANNELS);
wire hit_freq = in_range(addr_i, `COIL_FREQ_EN, `IN_CHANNELS);
wire hit_clr = in_range(addr_i, `COIL_CLR_CNT, `IN_CHANNELS);
wire hit_hl = in_range(addr_i, `DI_HIGH_LATCH, `IN_CHANNELS);
wire [15:0] oidx_out = addr_i - `COIL_OUT_STATE;
wire [15:0] oidx_pwm = addr_i - `COIL_PWM_EN;
wire [15:0] oidx_pwron = addr_i - `COIL_PWRON;
wire [15:0] oidx_safe = addr_i - `COIL_SAFE;
wire [15:0] iidx_cnt = addr_i - `COIL_CNT_EN;
wire [15:0] iidx_freq = addr_i - `COIL_FREQ_EN;
wire [15:0] iidx_clr = addr_i - `COIL_CLR_CNT;
wire [15:0] iidx_hl = addr_i - `DI_HIGH_LATCH;
wire bitv = wdata_i[0];
wire wdt_enabled = at_least(wdt_to_r, `WDT_MIN_S);
wire sec_tick = (tick_r == SECOND_CYCLES - 1);
wire wdt_expire = wdt_enabled && !wdt_fault_r && sec_tick && (wdt_sec_r + 16'h0001 >= wdt_to_r);
wire clr_hi = pulse_hit(coil_we, addr_i, `COIL_CLR_HIGH, bitv);
wire clr_lo = pulse_hit(coil_we, addr_i, `COIL_CLR_LOW, bitv);
wire [`IN_CHANNELS-1:0] rise = din_s2_r & ~din_prev_r;
wire [`IN_CHANNELS-1:0] fall = ~din_s2_r & din_prev_r;

////////////////////////////////////////////////////////////////////////////////
// Coils and holding registers

always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        out_state_r <= {`OUT_CHANNELS{1'b0}};
        pwm_en_r <= {`OUT_CHANNELS{1'b0}};
        pwron_r <= {`OUT_CHANNELS{1'b0}};
        safe_r <= {`OUT_CHANNELS{1'b0}};
        cnt_en_r <= {`IN_CHANNELS{1'b0}};
        freq_en_r <= {`IN_CHANNELS{1'b0}};
        latch_en_r <= 1'b0;
        wdt_to_r <= `WDT_TIMEOUT_RST;
        conn_to_r <= `CONN_TIMEOUT_RST;
        sys_to_r <= `SYS_TIMEOUT_RST;
        pwron_done_r <= 1'b0;
    end else if (en_i) begin
        // Power-on values load once after reset; a later write still wins
        if (!pwron_done_r) begin
            out_state_r <= pwron_r;
            pwron_done_r <= 1'b1;
        end
        if (coil_we) begin
            if (hit_out)
                out_state_r[oidx_out[0]] <= bitv;
            if (hit_pwm)
                pwm_en_r[oidx_pwm[0]] <= bitv;
            if (hit_pwron)
                pwron_r[oidx_pwron[0]] <= bitv;
            if (hit_safe)
                safe_r[oidx_safe[0]] <= bitv;
            if (hit_cnt)
                cnt_en_r[iidx_cnt[0]] <= bitv;
            if (hit_freq)
                freq_en_r[iidx_freq[0]] <= bitv;
            if (addr_i == `COIL_LATCH_EN)
                latch_en_r <= bitv;
        end
        if (hr_wr_i) begin
            case (addr_i)
                `HR_WDT_TIMEOUT: wdt_to_r <= wdata_i;
                `HR_CONN_TIMEOUT: conn_to_r <= wdata_i;
                `HR_SYS_TIMEOUT: sys_to_r <= wdata_i;
                default: ;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Input latches, set wins over clear

always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        hi_latch_r <= {`IN_CHANNELS{1'b0}};
        lo_latch_r <= {`IN_CHANNELS{1'b0}};
    end else if (en_i) begin
        hi_latch_r <= ((clr_hi ? {`IN_CHANNELS{1'b0}} : hi_latch_r)
                      | (latch_en_r ? rise : {`IN_CHANNELS{1'b0}}));
        lo_latch_r <= ((clr_lo ? {`IN_CHANNELS{1'b0}} : lo_latch_r)
                      | (latch_en_r ? fall : {`IN_CHANNELS{1'b0}}));
    end
end

////////////////////////////////////////////////////////////////////////////////
// Host watchdog, reset cause and event counter

reg [15:0] wdt_sec_nxt;
reg wdt_fault_nxt;
reg [15:0] wdt_events_nxt;
always @* begin
    wdt_sec_nxt = wdt_sec_r;
    wdt_fault_nxt = wdt_fault_r;
    wdt_events_nxt = wdt_events_r;
    // An expiry in the same cycle as host traffic still counts: the set wins
    if (!wdt_enabled) begin
        wdt_sec_nxt = 16'h0000;
        wdt_fault_nxt = 1'b0;
    end else if (wdt_expire) begin
        wdt_fault_nxt = 1'b1;
        wdt_events_nxt = wdt_events_r + 16'h0001;
    end else if (host_activity_i) begin
        // Activity restarts the count and ends a fault; outputs return to their coils
        wdt_sec_nxt = 16'h0000;
        wdt_fault_nxt = 1'b0;
    end else if (sec_tick && !wdt_fault_r) begin
        wdt_sec_nxt = wdt_sec_r + 16'h0001;
    end
end

always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        tick_r <= 32'h00000000;
        wdt_sec_r <= 16'h0000;
        wdt_fault_r <= 1'b0;
        wdt_events_r <= 16'h0000;
        cause_r <= `CAUSE_POWER_ON;
    end else if (en_i) begin
        if (sec_tick)
            tick_r <= 32'h00000000;
        else
            tick_r <= tick_r + 32'h00000001;
        wdt_sec_r <= wdt_sec_nxt;
        wdt_fault_r <= wdt_fault_nxt;
        wdt_events_r <= wdt_events_nxt;
        // A processor reset request is recorded before the system reset lands
        if (wdt_reset_i)
            cause_r <= `CAUSE_WATCHDOG;
        else if (cmd_reset_i)
            cause_r <= `CAUSE_COMMAND;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read port and outputs

reg [15:0] rd_nxt;
reg err_nxt;
always @* begin
    rd_nxt = 16'h0000;
    err_nxt = 1'b0;
    if (coil_rd_i) begin
        if (hit_out)
            rd_nxt = bit_word(out_state_r[oidx_out[0]]);
        else if (hit_pwm)
            rd_nxt = bit_word(pwm_en_r[oidx_pwm[0]]);
        else if (hit_pwron)
            rd_nxt = bit_word(pwron_r[oidx_pwron[0]]);
        else if (hit_safe)
            rd_nxt = bit_word(safe_r[oidx_safe[0]]);
        else if (hit_cnt)
            rd_nxt = bit_word(cnt_en_r[iidx_cnt[0]]);
        else if (hit_freq)
            rd_nxt = bit_word(freq_en_r[iidx_freq[0]]);
        else if (addr_i == `COIL_LATCH_EN)
            rd_nxt = bit_word(latch_en_r);
        else
            err_nxt = 1'b1; // Write-only pulse coils are not readable
    end else if (di_rd_i) begin
        if (hit_hl)
            rd_nxt = bit_word(hi_latch_r[iidx_hl[0]]);
        else
            err_nxt = 1'b1;
    end else if (hr_rd_i) begin
        case (addr_i)
            `HR_RESET_CAUSE: rd_nxt = cause_r;
            `HR_WDT_TIMEOUT: rd_nxt = wdt_to_r;
            `HR_WDT_EVENTS: rd_nxt = wdt_events_r;
            `HR_MODULE_NAME: rd_nxt = MODULE_NAME;
            `HR_CONN_TIMEOUT: rd_nxt = conn_to_r;
            `HR_SYS_TIMEOUT: rd_nxt = sys_to_r;
            default: err_nxt = 1'b1;
        endcase
    end
end

integer i;
reg [`IN_CHANNELS-1:0] clr_nxt;
always @* begin
    clr_nxt = {`IN_CHANNELS{1'b0}};
    for (i = 0; i < `IN_CHANNELS; i = i + 1)
        if (coil_we && hit_clr && bitv && iidx_clr[0] == i[0])
            clr_nxt[i] = 1'b1;
end

always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        rdata_o <= 16'h0000;
        rvalid_o <= 1'b0;
        rerr_o <= 1'b0;
        dout_o <= {`OUT_CHANNELS{1'b0}};
        pwm_en_o <= {`OUT_CHANNELS{1'b0}};
        cnt_en_o <= {`IN_CHANNELS{1'b0}};
        freq_en_o <= {`IN_CHANNELS{1'b0}};
        latch_en_o <= 1'b0;
        cnt_clr_o <= {`IN_CHANNELS{1'b0}};
        save_o <= 1'b0;
        high_latch_o <= {`IN_CHANNELS{1'b0}};
        low_latch_o <= {`IN_CHANNELS{1'b0}};
        safe_state_o <= 1'b0;
        conn_timeout_en_o <= 1'b0;
        sys_timeout_en_o <= 1'b0;
        conn_timeout_o <= 16'h0000;
        sys_timeout_o <= 16'h0000;
        in_count_o <= 8'h00;
        out_count_o <= 8'h00;
    end else if (en_i) begin
        rdata_o <= rd_nxt;
        rvalid_o <= coil_rd_i | di_rd_i | hr_rd_i;
        rerr_o <= err_nxt;
        dout_o <= wdt_fault_r ? safe_r : out_state_r;
        // PWM is relay-unfriendly; the enable is passed on, forced off only during a watchdog fault, and policing it is left to software
        pwm_en_o <= wdt_fault_r ? {`OUT_CHANNELS{1'b0}} : pwm_en_r;
        cnt_en_o <= cnt_en_r;
        freq_en_o <= freq_en_r;
        latch_en_o <= latch_en_r;
        cnt_clr_o <= clr_nxt;
        save_o <= pulse_hit(coil_we, addr_i, `COIL_SAVE, bitv) && !flash_busy_i;
        high_latch_o <= hi_latch_r;
        low_latch_o <= lo_latch_r;
        safe_state_o <= wdt_fault_r;
        conn_timeout_en_o <= at_least(conn_to_r, `CONN_MIN_S);
        sys_timeout_en_o <= at_least(sys_to_r, `SYS_MIN_S);
        conn_timeout_o <= conn_to_r;
        sys_timeout_o <= sys_to_r;
        in_count_o <= `IN_CHANNELS;
        out_count_o <= `OUT_CHANNELS;
    end
end

endmodule
`default_nettype wire

// ### verif/remote_io_checker_assertions.sv
// Concurrent checks on the remote I/O register bank ports
`timescale 1ns/1ps
`default_nettype none
module remote_io_checker (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic en_i,
    input wire logic coil_wr_i,
    input wire logic coil_rd_i,
    input wire logic di_rd_i,
    input wire logic hr_rd_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic flash_busy_i,
    input wire logic [15:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic rerr_o,
    input wire logic [1:0] cnt_clr_o,
    input wire logic save_o,
    input wire logic safe_state_o,
    input wire logic [1:0] pwm_en_o,
    input wire logic conn_timeout_en_o,
    input wire logic sys_timeout_en_o,
    input wire logic [15:0] conn_timeout_o,
    input wire logic [15:0] sys_timeout_o,
    input wire logic [7:0] in_count_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    wire rd_any = en_i && (coil_rd_i || di_rd_i || hr_rd_i);
    wire wr_one = en_i && coil_wr_i && wdata_i[0];
    ////////////////////////////////////////////////////////////////////////////////
    read_answer_a: assert property (rd_any |=> rvalid_o)
        else $error("read strobe got no answer");
    answer_cause_a: assert property (rvalid_o |-> $past(rd_any))
        else $error("answer without a read strobe");
    refuse_data_a: assert property (rerr_o |-> rvalid_o && rdata_o == 16'h0000)
        else $error("refused read carries data");
    conn_enable_a: assert property (!$stable(conn_timeout_o) |->
        ##[0:1] (conn_timeout_en_o == (conn_timeout_o >= 16'h0005)))
        else $error("connection timeout enable wrong");
    sys_enable_a: assert property (!$stable(sys_timeout_o) |->
        ##[0:1] (sys_timeout_en_o == (sys_timeout_o >= 16'h001E)))
        else $error("system timeout enable wrong");
    clear_pulse_a: assert property (wr_one && addr_i == 16'h0023 |-> ##[1:2] cnt_clr_o == 2'b10)
        else $error("counter clear pulse missing");
    save_pulse_a: assert property (wr_one && addr_i == 16'h003C && !flash_busy_i |-> ##[1:2] save_o)
        else $error("save pulse missing");
    save_short_a: assert property (save_o |=> !save_o)
        else $error("save pulse too long");
    fault_pwm_a: assert property (safe_state_o && $past(safe_state_o) |-> pwm_en_o == 2'b00)
        else $error("modulation kept in fault");
    variant_count_a: assert property (rvalid_o |-> in_count_o == 8'h02)
        else $error("input channel count wrong");
endmodule
`default_nettype wire

// ### verif/modbus_client_model.sv
// Behavioural client issuing one register access at a time
`timescale 1ns/1ps
`default_nettype none
module modbus_client_model (
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i,
    input wire logic rerr_i,
    output logic [4:0] stb_o,
    output logic [15:0] addr_o,
    output logic [15:0] wdata_o
);
    initial begin
        stb_o = 5'h00;
        addr_o = 16'hFFFF;
        wdata_o = 16'hFFFF;
    end
    // Idle lines show the inverse of the last value, so stale data never looks fresh
    task automatic xfer(input int k, input logic [15:0] a, d, output logic [15:0] q,
                        output logic [1:0] f);
        @(posedge clk_i);
        stb_o <= 5'h01 << k;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        stb_o <= 5'h00;
        addr_o <= ~a;
        wdata_o <= ~d;
        #1;
        q = rdata_i;
        f = {rvalid_i, rerr_i};
    endtask
endmodule
`default_nettype wire

// ### verif/remote_io_control_registers_bench.sv
// Self-checking bench for the remote I/O register bank
`timescale 1ns/1ps
`default_nettype none
module remote_io_control_registers_bench;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic en_i = 1'b1;
    logic flash_busy_i = 1'b0;
    logic host_activity_i = 1'b0;
    logic cmd_reset_i = 1'b0;
    logic wdt_reset_i = 1'b0;
    logic [1:0] din_i = 2'b00;
    logic [4:0] stb;
    logic [15:0] addr, wdata, rdata_o, q, conn_timeout_o, sys_timeout_o;
    logic rvalid_o, rerr_o, safe_state_o, latch_en_o, save_o, conn_timeout_en_o, sys_timeout_en_o;
    logic [1:0] f, dout_o, pwm_en_o, cnt_en_o, freq_en_o, cnt_clr_o, high_latch_o, low_latch_o;
    logic [7:0] in_count_o, out_count_o;
    logic [15:0] cfg [6] = '{16'h0064, 16'h0096, 16'h0097, 16'h00BE, 16'h00EB, 16'h010B};
    int err_count = 0;
    int n_compared = 0;
    initial forever #20 clk_i = ~clk_i;
    modbus_client_model i_cli (.clk_i(clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
        .rerr_i(rerr_o), .stb_o(stb), .addr_o(addr), .wdata_o(wdata));
    remote_io_control_registers #(.SECOND_CYCLES(10)) i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .en_i(en_i), .coil_wr_i(stb[0]), .coil_rd_i(stb[1]), .di_rd_i(stb[2]), .hr_wr_i(stb[3]),
        .hr_rd_i(stb[4]), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .rerr_o(rerr_o), .host_activity_i(host_activity_i), .cmd_reset_i(cmd_reset_i),
        .wdt_reset_i(wdt_reset_i), .din_i(din_i), .flash_busy_i(flash_busy_i), .dout_o(dout_o),
        .pwm_en_o(pwm_en_o), .cnt_en_o(cnt_en_o), .freq_en_o(freq_en_o), .latch_en_o(latch_en_o),
        .cnt_clr_o(cnt_clr_o), .save_o(save_o), .high_latch_o(high_latch_o),
        .low_latch_o(low_latch_o), .safe_state_o(safe_state_o),
        .conn_timeout_en_o(conn_timeout_en_o), .sys_timeout_en_o(sys_timeout_en_o),
        .conn_timeout_o(conn_timeout_o), .sys_timeout_o(sys_timeout_o),
        .in_count_o(in_count_o), .out_count_o(out_count_o));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [17:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input int k, input logic [15:0] a, d);
        i_cli.xfer(k, a, d, q, f);
    endtask
    task automatic rd(input int k, input logic [15:0] a, exp, input logic er, input string nm);
        i_cli.xfer(k, a, 16'h0000, q, f);
        chk(nm, {f, q}, {1'b1, er, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Pulses last one cycle, so each of the three cycles after the write is sampled
    task automatic pulse(input logic [15:0] a, input logic [2:0] exp, input string nm);
        logic [2:0] seen;
        seen = 3'b000;
        wr(0, a, 16'h0001);
        for (int i = 0; i < 3; i++) begin
            seen = seen | {save_o, cnt_clr_o};
            tick(1);
        end
        chk(nm, seen, exp);
        chk("pulse ended", {save_o, cnt_clr_o}, 3'b000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(4, 16'h00FF, 16'h0001, 1'b0, "reset cause");
        rd(4, 16'h0101, 16'h0000, 1'b0, "watchdog timeout");
        rd(4, 16'h0102, 16'h0000, 1'b0, "watchdog events");
        rd(4, 16'h0108, 16'h0000, 1'b0, "system timeout");
        for (int i = 0; i < 6; i++) rd(1, cfg[i], 16'h0000, 1'b0, "coil default");
        chk("channel counts", {in_count_o, out_count_o}, 16'h0202);
        $display("test reset values done");
    endtask
    task automatic t_coils;
        wr(0, 16'h0001, 16'h0001);
        wr(0, 16'h0065, 16'h0001); // modulation is run only briefly
        wr(0, 16'h0096, 16'h0001);
        wr(0, 16'h0098, 16'h0001);
        wr(0, 16'h00BE, 16'h0001);
        tick(1);
        chk("outputs", dout_o, 2'b10);
        chk("pwm enables", pwm_en_o, 2'b10);
        chk("latch enable", latch_en_o, 1'b1);
        chk("counter enables", cnt_en_o, 2'b10);
        chk("frequency enables", freq_en_o, 2'b01);
        rd(1, 16'h0001, 16'h0001, 1'b0, "output coil");
        wr(0, 16'h0065, 16'h0000);
        $display("test coils done");
    endtask
    task automatic t_timeouts;
        wr(3, 16'h0107, 16'h0004);
        wr(3, 16'h0108, 16'h001D);
        tick(1);
        chk("enables below limit", {conn_timeout_en_o, sys_timeout_en_o}, 2'b00);
        wr(3, 16'h0107, 16'h0005);
        wr(3, 16'h0108, 16'h001E);
        tick(1);
        chk("enables at limit", {conn_timeout_en_o, sys_timeout_en_o}, 2'b11);
        chk("connection value", conn_timeout_o, 16'h0005);
        chk("system value", sys_timeout_o, 16'h001E);
        rd(4, 16'h0107, 16'h0005, 1'b0, "connection timeout");
        rd(4, 16'h0108, 16'h001E, 1'b0, "system timeout");
        $display("test timeouts done");
    endtask
    task automatic t_latches;
        @(posedge clk_i) din_i <= 2'b01;
        @(posedge clk_i);
        repeat (4) @(posedge clk_i);
        din_i <= 2'b00;
        tick(5);
        chk("high latches", high_latch_o, 2'b01);
        chk("low latches", low_latch_o, 2'b01);
        rd(2, 16'h0020, 16'h0001, 1'b0, "latched flag");
        rd(2, 16'h0021, 16'h0000, 1'b0, "unlatched flag");
        wr(0, 16'h0020, 16'h0001);
        tick(1);
        chk("high cleared", {high_latch_o, low_latch_o}, 4'b0001);
        wr(0, 16'h0021, 16'h0001);
        tick(1);
        chk("low cleared", low_latch_o, 2'b00);
        pulse(16'h0023, 3'b010, "counter clear");
        pulse(16'h003C, 3'b100, "save pulse");
        $display("test latches and pulses done");
    endtask
    task automatic t_watchdog;
        wr(0, 16'h010B, 16'h0001);
        wr(3, 16'h0101, 16'h0004);
        tick(80);
        chk("no expiry below five", safe_state_o, 1'b0);
        wr(0, 16'h0064, 16'h0001); // modulation is enabled for this test and must be forced off during the fault
        wr(3, 16'h0101, 16'h0005);
        for (int i = 0; i < 120 && safe_state_o !== 1'b1; i++) @(posedge clk_i);
        tick(1);
        chk("fault state", safe_state_o, 1'b1);
        chk("safe outputs", dout_o, 2'b01);
        chk("modulation in fault", pwm_en_o, 2'b00);
        rd(4, 16'h0102, 16'h0001, 1'b0, "event count");
        wr(3, 16'h0101, 16'h0000);
        @(posedge clk_i) host_activity_i <= 1'b1;
        @(posedge clk_i) host_activity_i <= 1'b0;
        tick(3);
        chk("outputs restored", dout_o, 2'b10);
        chk("modulation restored", pwm_en_o, 2'b01);
        wr(0, 16'h0064, 16'h0000);
        $display("test watchdog done");
    endtask
    task automatic t_hold;
        @(posedge clk_i) en_i <= 1'b0;
        wr(0, 16'h0000, 16'h0001);
        @(posedge clk_i) en_i <= 1'b1;
        tick(2);
        chk("write while frozen", dout_o, 2'b10);
        @(posedge clk_i) flash_busy_i <= 1'b1;
        pulse(16'h003C, 3'b000, "save while busy");
        @(posedge clk_i) flash_busy_i <= 1'b0;
        $display("test clock enable and busy flash done");
    endtask
    task automatic t_cause;
        @(posedge clk_i) cmd_reset_i <= 1'b1;
        @(posedge clk_i) cmd_reset_i <= 1'b0;
        rd(4, 16'h00FF, 16'h0003, 1'b0, "commanded cause");
        @(posedge clk_i) wdt_reset_i <= 1'b1;
        @(posedge clk_i) wdt_reset_i <= 1'b0;
        wr(3, 16'h00FF, 16'h0007);
        rd(4, 16'h00FF, 16'h0002, 1'b0, "watchdog cause");
        rd(1, 16'h0020, 16'h0000, 1'b1, "write-only coil");
        rd(4, 16'h0200, 16'h0000, 1'b1, "unmapped register");
        $display("test reset cause done");
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        t_reset;
        t_coils;
        t_timeouts;
        t_latches;
        t_watchdog;
        t_hold;
        t_cause;
        wrap_up;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        err_count++;
        wrap_up;
    end
endmodule
bind remote_io_control_registers remote_io_checker i_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .en_i(en_i), .coil_wr_i(coil_wr_i), .coil_rd_i(coil_rd_i), .di_rd_i(di_rd_i),
    .hr_rd_i(hr_rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .flash_busy_i(flash_busy_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .rerr_o(rerr_o), .cnt_clr_o(cnt_clr_o),
    .save_o(save_o), .safe_state_o(safe_state_o), .pwm_en_o(pwm_en_o),
    .conn_timeout_en_o(conn_timeout_en_o), .sys_timeout_en_o(sys_timeout_en_o),
    .conn_timeout_o(conn_timeout_o), .sys_timeout_o(sys_timeout_o), .in_count_o(in_count_o));
`default_nettype wire
